// ==== hw/sensor_target.v ====
// Two-wire target of a humidity/temperature sensor: framing, address,
// acknowledge, trigger command, status byte and result read-out.
// Assumes scl/sda arrive asynchronously from the pads; open-drain
// pads are resolved outside, sda_oe high pulls the line low.
//
// Behaviour
// RULE1 - Ignore bus until power-up settling elapsed
// RULE2 - Only start-to-stop framed transfers count
// RULE3 - Host ends transfer: sda rises, scl high
// RULE4 - After stop, idle until next start
// RULE5 - Answer only to fixed address 0x38
// RULE6 - Address lsb one reads, zero writes
// RULE7 - Acknowledge each good byte after eighth fall
// RULE8 - Host waits for conversion before reading
// RULE9 - Status bit 7 one while measuring
// RULE10 - Status bit 7 zero when idle
// RULE11 - Status bits 4,3 set means calibrated
// RULE12 - Trigger command carries 0x33 then 0x00
// RULE13 - Six result bytes follow status when idle
// RULE14 - Seventh byte crc-8, poly 0x31, init 0xff
// RULE15 - Wrong address leaves sda released
`include "sensor_target_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module sensor_target #(
  parameter SETTLE_CYC = `SETTLE_CYC,
  parameter CONV_CYC = `CONV_CYC
) (
  input wire ref_clk, // 250 MHz clock
  input wire rst, // Synchronous reset, active high
  input wire scl_in, // Serial clock pin level
  input wire sda_in, // Serial data pin level
  input wire [19:0] hum_sample, // Humidity conversion result
  input wire [19:0] temp_sample, // Temperature conversion result
  output reg sda_oe_ff, // High pulls sda low
  output reg sda_out_ff, // Always low when driving
  output reg ready_ff, // Settling done
  output reg busy_ff, // Measurement in progress
  output reg [7:0] state_byte_ff // Measurement state byte
);
  localparam S_IDLE = 3'd0; // Waiting for start
  localparam S_ADDR = 3'd1; // Shifting address byte
  localparam S_WR = 3'd2; // Receiving command bytes
  localparam S_RD = 3'd3; // Sending bytes
  localparam S_ACK = 3'd4; // Driving acknowledge
  localparam S_MACK = 3'd5; // Sampling host acknowledge

  reg [2:0] scl_s_ff, sda_s_ff; // Three-stage synchronisers
  reg scl_q_ff, sda_q_ff; // Last agreed levels
  reg [31:0] settle_ff; // Power-up settle counter
  reg [31:0] conv_ff; // Conversion counter
  reg [2:0] st_ff; // Protocol state
  reg [2:0] bit_ff; // Bit index within byte
  reg [7:0] sh_ff; // Shift register
  reg rd_ff; // Current transfer is a read
  reg [1:0] wcnt_ff; // Write byte count in transfer
  reg [7:0] cmd_ff; // First command byte
  reg p0_ok_ff; // First parameter byte correct
  reg [2:0] rptr_ff; // Read byte pointer, also the memory slot
  reg cal_ff; // Calibrated flag
  reg [7:0] crc_ff; // Running crc while filling
  reg [2:0] fill_ff; // Fill index
  reg filling_ff; // Result bytes being written
  reg [7:0] fdata; // Fill byte
  reg mem_we; // Memory write strobe
  reg trig_go; // Trigger command complete, one cycle
  reg init_go; // Initialisation command complete, one cycle
  wire [7:0] mem_q; // Memory read data
  wire scl_hi, sda_hi, scl_rise, scl_fall, start_ev, stop_ev;
  wire [7:0] byte_in;
  wire [39:0] frame = {hum_sample, temp_sample}; // Result order

  // crc-8 over one byte, poly x^8+x^5+x^4+1, msb first
  function [7:0] crc8;
    input [7:0] c;
    input [7:0] d;
    integer i;
    reg [7:0] r;
    begin
      r = c ^ d;
      for (i = 0; i < 8; i = i + 1) begin
        r = r[7] ? ((r << 1) ^ `CRC_POLY) : (r << 1);
      end
      crc8 = r;
    end
  endfunction

  // Pin synchronisers; stages 2 and 3 must agree before a change counts
  always @(posedge ref_clk) begin
    if (rst) begin
      scl_s_ff <= 3'h7;
      sda_s_ff <= 3'h7;
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_s_ff <= {scl_s_ff[1:0], scl_in};
      sda_s_ff <= {sda_s_ff[1:0], sda_in};
      if (scl_s_ff[1] == scl_s_ff[2]) begin
        scl_q_ff <= scl_s_ff[2];
      end
      if (sda_s_ff[1] == sda_s_ff[2]) begin
        sda_q_ff <= sda_s_ff[2];
      end
    end
  end

  assign scl_hi = (scl_s_ff[1] == scl_s_ff[2]) ? scl_s_ff[2] : scl_q_ff;
  assign sda_hi = (sda_s_ff[1] == sda_s_ff[2]) ? sda_s_ff[2] : sda_q_ff;
  assign scl_rise = scl_hi & ~scl_q_ff;
  assign scl_fall = ~scl_hi & scl_q_ff;
  // Framing conditions only while clock stays high
  assign start_ev = scl_q_ff & scl_hi & sda_q_ff & ~sda_hi; // RULE2
  assign stop_ev = scl_q_ff & scl_hi & ~sda_q_ff & sda_hi; // RULE3
  assign byte_in = {sh_ff[6:0], sda_hi};
  // Status byte: busy on bit 7; reserved bit 4 reads one alongside the
  // calibrated bit 3, so a host masking with bits 4 and 3 sees it ready
  wire [7:0] nxt_state_byte = {busy_ff, 2'b00, cal_ff, // RULE9 RULE10
    cal_ff, 3'b000}; // RULE11

  // Result byte generator for the fill sequence
  always @* begin
    case (fill_ff)
      3'd0: fdata = nxt_state_byte;
      3'd1: fdata = frame[39:32];
      3'd2: fdata = frame[31:24];
      3'd3: fdata = frame[23:16];
      3'd4: fdata = frame[15:8];
      3'd5: fdata = frame[7:0];
      default: fdata = crc_ff; // RULE14
    endcase
    mem_we = filling_ff;
  end

  result_mem #(.AW(3), .DEPTH(`RESULT_BYTES)) result_mem_i (
    .clk(ref_clk),
    .we(mem_we),
    .waddr(fill_ff),
    .wdata(fdata),
    .raddr(rptr_ff),
    .rdata_ff(mem_q)
  );

  // Settle and conversion timers, status register
  always @(posedge ref_clk) begin
    if (rst) begin
      settle_ff <= 32'h0;
      ready_ff <= 1'b0;
      conv_ff <= 32'h0;
      busy_ff <= 1'b0;
      cal_ff <= 1'b1;
      filling_ff <= 1'b0;
      fill_ff <= 3'h0;
      crc_ff <= `CRC_INIT;
      state_byte_ff <= 8'h00;
    end else begin
      state_byte_ff <= nxt_state_byte;
      // Commands are ignored until the settle window passes
      if (!ready_ff) begin
        if (settle_ff == SETTLE_CYC - 1) begin
          ready_ff <= 1'b1; // RULE1
        end else begin
          settle_ff <= settle_ff + 32'h1;
        end
      end
      // Conversion runs, then the frame is latched into memory
      if (trig_go) begin
        busy_ff <= 1'b1; // RULE9
        conv_ff <= 32'h0;
      end else if (busy_ff) begin
        if (conv_ff == CONV_CYC - 1) begin
          busy_ff <= 1'b0; // RULE10
          filling_ff <= 1'b1;
          fill_ff <= 3'h0;
          crc_ff <= `CRC_INIT;
        end else begin
          conv_ff <= conv_ff + 32'h1;
        end
      end
      if (filling_ff) begin
        crc_ff <= crc8(crc_ff, fdata); // RULE14
        fill_ff <= fill_ff + 3'h1;
        // The crc byte at index 6 is the last one written
        filling_ff <= (fill_ff != 3'd6);
      end
      cal_ff <= cal_ff | init_go; // RULE11
    end
  end

  // Byte-level protocol engine on synchronised edges
  always @(posedge ref_clk) begin
    if (rst) begin
      st_ff <= S_IDLE;
      bit_ff <= 3'h0;
      sh_ff <= 8'h00;
      rd_ff <= 1'b0;
      wcnt_ff <= 2'h0;
      cmd_ff <= 8'h00;
      p0_ok_ff <= 1'b0;
      rptr_ff <= 3'h0;
      sda_oe_ff <= 1'b0;
      sda_out_ff <= 1'b0;
      trig_go <= 1'b0;
      init_go <= 1'b0;
    end else begin
      trig_go <= 1'b0;
      init_go <= 1'b0;
      if (!ready_ff || stop_ev) begin
        st_ff <= S_IDLE; // RULE1 RULE4
        sda_oe_ff <= 1'b0;
      end else if (start_ev) begin
        st_ff <= S_ADDR; // RULE2
        bit_ff <= 3'h0;
        wcnt_ff <= 2'h0;
        sda_oe_ff <= 1'b0;
      end else begin
        case (st_ff)
          S_ADDR, S_WR: begin
            if (scl_rise) begin
              sh_ff <= byte_in;
              bit_ff <= bit_ff + 3'h1;
              if (bit_ff == 3'd7) begin
                st_ff <= S_ACK;
                if (st_ff == S_ADDR) begin
                  rd_ff <= sda_hi; // RULE6
                  rptr_ff <= 3'h0;
                  if (sh_ff[6:0] != `TARGET_ADDR) begin
                    st_ff <= S_IDLE; // RULE5 RULE15
                  end
                end else begin
                  wcnt_ff <= (wcnt_ff == 2'd3) ? wcnt_ff : wcnt_ff + 2'h1;
                  if (wcnt_ff == 2'd0) begin
                    cmd_ff <= byte_in;
                    init_go <= (byte_in == `CMD_INIT);
                  end else if (wcnt_ff == 2'd1) begin
                    p0_ok_ff <= (byte_in == `TRIG_PARAM0);
                  end else if (wcnt_ff == 2'd2) begin
                    // RULE12 RULE8
                    trig_go <= (cmd_ff == `CMD_TRIGGER) & p0_ok_ff &
                      (byte_in == `TRIG_PARAM1) & ~busy_ff;
                  end
                end
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              if (!sda_oe_ff) begin
                sda_oe_ff <= 1'b1; // RULE7
              end else begin
                sda_oe_ff <= 1'b0;
                bit_ff <= 3'h0;
                if (rd_ff) begin
                  st_ff <= S_RD;
                  sh_ff <= state_byte_ff;
                  sda_oe_ff <= ~state_byte_ff[7];
                end else begin
                  st_ff <= S_WR;
                end
              end
            end
          end
          S_RD: begin
            if (scl_fall) begin
              bit_ff <= bit_ff + 3'h1;
              if (bit_ff == 3'd7) begin
                st_ff <= S_MACK;
                sda_oe_ff <= 1'b0;
                rptr_ff <= rptr_ff + 3'h1;
              end else begin
                sh_ff <= {sh_ff[6:0], 1'b0};
                sda_oe_ff <= ~sh_ff[6];
              end
            end
          end
          S_MACK: begin
            // Host nack ends the read; stop follows
            if (scl_rise && sda_hi) begin
              st_ff <= S_IDLE; // RULE14
            end else if (scl_fall) begin
              bit_ff <= 3'h0;
              st_ff <= S_RD;
              // Live status went out first; slot k of the latched frame
              // holds read byte k, so the pointer addresses it directly
              sh_ff <= mem_q; // RULE13
              sda_oe_ff <= ~mem_q[7]; // RULE13
            end
          end
          // Idle and unused codes: wait for a start with sda released
          default: begin
            st_ff <= S_IDLE;
            sda_oe_ff <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // sensor_target
`default_nettype wire

// ==== hw/sensor_target_defs.vh ====
// Constants for the humidity/temperature sensor two-wire target.
// Assumes a 250 MHz ref_clk; times are given in their own units.
`ifndef SENSOR_TARGET_DEFS_VH
`define SENSOR_TARGET_DEFS_VH
`define CLK_MHZ 250
`define SETTLE_MS 100
`define SETTLE_CYC (`SETTLE_MS * 1000 * `CLK_MHZ)
`define CONV_MS 80
`define CONV_CYC (`CONV_MS * 1000 * `CLK_MHZ)
`define TARGET_ADDR 7'h38
`define CMD_TRIGGER 8'hac
`define CMD_STATUS 8'h71
`define CMD_INIT 8'hbe
`define TRIG_PARAM0 8'h33
`define TRIG_PARAM1 8'h00
`define ST_BUSY_BIT 7
`define ST_FIXED_BIT 4
`define ST_CAL_BIT 3
`define CRC_POLY 8'h31
`define CRC_INIT 8'hff
`define RESULT_BYTES 7
`endif

// ==== hw/result_mem.v ====
// Small result memory: seven bytes of measurement frame with crc.
// Assumes one clock; read data is registered.
`timescale 1ns/1ps
`default_nettype none
module result_mem #(
  parameter AW = 3,
  parameter DEPTH = 7
) (
  input wire clk, // Clock
  input wire we, // Write strobe
  input wire [AW-1:0] waddr, // Write address
  input wire [7:0] wdata, // Write data
  input wire [AW-1:0] raddr, // Read address
  output reg [7:0] rdata_ff // Registered read data
);
  reg [7:0] mem [0:DEPTH-1]; // Storage

  // Write port and registered read port
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_ff <= mem[raddr];
  end
endmodule // result_mem
`default_nettype wire

// ==== test/sensor_target_checker.sv ====
// Port-level checks of the sensor two-wire target.
// Assumes scl_in and sda_in are the resolved pin levels.
`timescale 1ns/1ps
`default_nettype none
module sensor_target_checker #(
  parameter CONV_CYC = 50
) (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Synchronous reset
  input wire logic scl_in, // Serial clock level
  input wire logic sda_in, // Serial data level
  input wire logic sda_oe_ff, // Device pulls sda low
  input wire logic sda_out_ff, // Driven level
  input wire logic ready_ff, // Settling done
  input wire logic busy_ff, // Measurement running
  input wire logic [7:0] state_byte_ff // Status byte
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  int busy_cnt_ff; // Cycles the current measurement has run
  // A stuck busy flag would hang every polling host, so bound it
  always_ff @(posedge ref_clk) begin
    if (rst || !busy_ff) begin
      busy_cnt_ff <= 0;
    end else begin
      busy_cnt_ff <= busy_cnt_ff + 1;
    end
  end
  sequence s_drive_change;
    $changed(sda_oe_ff);
  endsequence
  sequence s_stop;
    scl_in && $rose(sda_in);
  endsequence
  a_reset_quiet: assert property (
    disable iff (1'b0) rst |=> !sda_oe_ff && !ready_ff && !busy_ff)
    else $error("outputs active after reset");
  a_wait_settle: assert property (!ready_ff |-> !sda_oe_ff)
    else $error("sda driven before settling");
  a_ready_holds: assert property (ready_ff |=> ready_ff)
    else $error("ready dropped");
  a_out_low: assert property (!sda_out_ff)
    else $error("sda driven high");
  a_edge_low: assert property (s_drive_change |-> !scl_in)
    else $error("sda drive changed while scl high");
  a_stop_idle: assert property (
    s_stop |-> ##1 (!sda_oe_ff) [*8])
    else $error("sda driven after stop");
  // The status byte is registered from busy, so it trails by one cycle
  a_busy_bit: assert property (
    state_byte_ff[7] == $past(busy_ff))
    else $error("status bit 7 differs from busy");
  a_cal_flags: assert property (
    !$past(rst) |-> (state_byte_ff & 8'h7f) == 8'h18)
    else $error("calibrated flags wrong");
  a_busy_bounded: assert property (busy_cnt_ff <= CONV_CYC + 8)
    else $error("measurement never ends");
endmodule // sensor_target_checker
bind sensor_target sensor_target_checker #(.CONV_CYC(CONV_CYC))
  sensor_target_checker_i (.ref_clk(ref_clk), .rst(rst), .scl_in(scl_in),
  .sda_in(sda_in), .sda_oe_ff(sda_oe_ff), .sda_out_ff(sda_out_ff),
  .ready_ff(ready_ff), .busy_ff(busy_ff), .state_byte_ff(state_byte_ff));
`default_nettype wire

// ==== test/host_bus_model.sv ====
// Host controller model for the two-wire bus, open-drain outputs.
// Assumes the bench resolves both lines with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module host_bus_model #(
  parameter int HALF = 12
) (
  input wire logic ref_clk, // Bench clock
  input wire logic sda, // Resolved data line
  output logic scl_low, // High pulls scl low
  output logic sda_low // High pulls sda low
);
  // Both lines released at time zero; scl idles high outside frames
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Every change lands one small delay after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Sda falls with scl high; sda moves only a half period after scl
  task automatic start_c;
    tick(HALF);
    sda_low = 1'b0;
    tick(HALF);
    scl_low = 1'b0;
    tick(HALF);
    sda_low = 1'b1;
    tick(HALF);
    scl_low = 1'b1;
  endtask
  // Sda rises with scl high to close the frame
  task automatic stop_c;
    tick(HALF);
    sda_low = 1'b1;
    tick(HALF);
    scl_low = 1'b0;
    tick(HALF);
    sda_low = 1'b0;
  endtask
  // Pulls scl low with sda left high: no start, so what follows is
  // an unframed byte
  task automatic scl_down;
    tick(HALF);
    scl_low = 1'b1;
  endtask
  // One bit: set sda in scl low, sample at the end of scl high
  task automatic clk_bit(input logic b, output logic r);
    tick(HALF);
    sda_low = !b;
    tick(HALF);
    scl_low = 1'b0;
    tick(HALF);
    r = sda;
    scl_low = 1'b1;
  endtask
  // Eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] w, input logic ack_in,
                      output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) clk_bit(w[i], r[i]);
    clk_bit(ack_in, ack);
  endtask
endmodule // host_bus_model
`default_nettype wire

// ==== test/test_humidity_temp_sensor_i2c_target.sv ====
// Self-checking bench of the sensor two-wire target.
// Assumes host_bus_model and the bound checker are compiled first.
`include "sensor_target_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module test_humidity_temp_sensor_i2c_target;
  localparam int SETTLE = 1000; // Settle window, longer than one byte
  localparam int CONV = 2000; // Conversion, longer than a status poll
  logic ref_clk = 1'b0; // 250 MHz clock
  logic rst = 1'b1; // Synchronous reset
  logic [19:0] hum = 20'h5a3c1; // Humidity sample
  logic [19:0] temp = 20'h8f27e; // Temperature sample
  logic scl_low, sda_low; // Host pulls
  wire logic oe, out_lvl, ready, busy; // Device outputs
  wire logic [7:0] state_byte; // Status byte
  wire logic scl = !scl_low; // Pulled-up clock line
  wire logic sda = !(sda_low | oe); // Pulled-up data line
  int failures = 0; // Mismatch count
  int cmp_count = 0; // Comparison count
  always #2 ref_clk = ~ref_clk;
  sensor_target #(.SETTLE_CYC(SETTLE), .CONV_CYC(CONV)) sensor_target_i (
    .ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda),
    .hum_sample(hum), .temp_sample(temp), .sda_oe_ff(oe),
    .sda_out_ff(out_lvl), .ready_ff(ready), .busy_ff(busy),
    .state_byte_ff(state_byte));
  host_bus_model host_bus_model_i (.ref_clk(ref_clk), .sda(sda),
    .scl_low(scl_low), .sda_low(sda_low));
  task automatic give_verdict;
    $display("failures %0d compares %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Bounded wait for ready, or for busy to clear
  task automatic wait_on(input bit for_idle);
    int n;
    n = 0;
    while (!(for_idle ? busy === 1'b0 : ready === 1'b1) && n < 9000) begin
      @(posedge ref_clk);
      n++;
    end
    #1;
    if (n >= 9000) begin
      failures++;
      give_verdict;
    end
  endtask
  // Writes a byte; exp_ack 0 means the device pulled sda low
  task automatic put(input logic [7:0] d, input logic [7:0] exp_ack);
    logic [7:0] r;
    logic a;
    host_bus_model_i.xfer(d, 1'b1, r, a);
    check({7'h0, a}, exp_ack);
  endtask
  task automatic get(input logic [7:0] exp, input logic nack);
    logic [7:0] r;
    logic a;
    host_bus_model_i.xfer(8'hff, nack, r, a);
    check(r, exp);
  endtask
  // Independent crc of the six frame bytes
  function automatic logic [7:0] crc8(input logic [47:0] d);
    logic [7:0] c;
    c = `CRC_INIT;
    for (int i = 47; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `CRC_POLY : 8'h00);
    return c;
  endfunction
  // Address sent inside the settle window goes unanswered
  task automatic sc_early;
    check(state_byte, 8'h18);
    check({7'h0, ready}, 8'h00);
    host_bus_model_i.start_c;
    put({`TARGET_ADDR, 1'b0}, 8'h01);
    host_bus_model_i.stop_c;
  endtask
  // Plain status read once settled
  task automatic sc_status;
    wait_on(1'b0);
    check({7'h0, ready}, 8'h01);
    check({7'h0, out_lvl}, 8'h00);
    host_bus_model_i.start_c;
    put({`TARGET_ADDR, 1'b0}, 8'h00);
    put(`CMD_INIT, 8'h00);
    host_bus_model_i.stop_c;
    host_bus_model_i.start_c;
    put({`TARGET_ADDR, 1'b1}, 8'h00);
    get(8'h18, 1'b1);
    host_bus_model_i.stop_c;
  endtask
  // Foreign address, bad trigger parameter, then a byte with no start
  task automatic sc_wrong;
    host_bus_model_i.start_c;
    put({`TARGET_ADDR + 7'h01, 1'b0}, 8'h01);
    put(`CMD_TRIGGER, 8'h01);
    host_bus_model_i.stop_c;
    host_bus_model_i.start_c;
    put({`TARGET_ADDR, 1'b0}, 8'h00);
    put(`CMD_TRIGGER, 8'h00);
    put(`TRIG_PARAM0 + 8'h01, 8'h00);
    put(`TRIG_PARAM1, 8'h00);
    host_bus_model_i.stop_c;
    check({7'h0, busy}, 8'h00);
    host_bus_model_i.scl_down;
    put({`TARGET_ADDR, 1'b0}, 8'h01);
    host_bus_model_i.stop_c;
    check({7'h0, busy}, 8'h00);
  endtask
  // Trigger, poll while busy, then the full frame with crc
  task automatic sc_measure;
    logic [47:0] frame;
    frame = {8'h18, hum, temp};
    host_bus_model_i.start_c;
    put({`TARGET_ADDR, 1'b0}, 8'h00);
    put(`CMD_TRIGGER, 8'h00);
    put(`TRIG_PARAM0, 8'h00);
    put(`TRIG_PARAM1, 8'h00);
    host_bus_model_i.stop_c;
    check({7'h0, busy}, 8'h01);
    host_bus_model_i.start_c;
    put({`TARGET_ADDR, 1'b1}, 8'h00);
    get(8'h98, 1'b1);
    host_bus_model_i.stop_c;
    wait_on(1'b1);
    host_bus_model_i.start_c;
    put({`TARGET_ADDR, 1'b1}, 8'h00);
    for (int i = 5; i >= 0; i--) get(frame[i*8 +: 8], 1'b0);
    get(crc8(frame), 1'b1);
    host_bus_model_i.stop_c;
    check({7'h0, busy}, 8'h00);
  endtask
  // Reset for two cycles, then the scenarios in order
  initial begin
    repeat (2) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    sc_early;
    sc_status;
    sc_wrong;
    sc_measure;
    give_verdict;
  end
endmodule // test_humidity_temp_sensor_i2c_target
`default_nettype wire
